// ===== src/flash_bus_cycle.v
`timescale 1ns/1ps
// One asynchronous bus cycle: write strobe or read with sampled data
module flash_bus_cycle #(
    parameter SETUP_CYC = 2,
    parameter PULSE_CYC = 20,
    parameter READ_CYC  = 24,
    parameter HIGH_CYC  = 30
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        start,
    input  wire        is_read,
    input  wire [15:0] din_sync,
    output reg         ce_n,
    output reg         oe_n,
    output reg         we_n,
    output reg         drive,
    output reg  [15:0] rdata,
    output reg         done
);
    localparam S_IDLE  = 2'd0;
    localparam S_SETUP = 2'd1;
    localparam S_PULSE = 2'd2;
    localparam S_HIGH  = 2'd3;

    reg [1:0]  state;
    reg [7:0]  cnt;
    reg        rd;

    always @(posedge clk) begin
        if (rst) begin
            state <= S_IDLE;
            cnt   <= 8'h00;
            rd    <= 1'b0;
            ce_n  <= 1'b1;
            oe_n  <= 1'b1;
            we_n  <= 1'b1;
            drive <= 1'b0;
            rdata <= 16'h0000;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start) begin
                        rd    <= is_read;
                        ce_n  <= 1'b0;
                        drive <= ~is_read;
                        cnt   <= 8'h00;
                        state <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == SETUP_CYC[7:0]) begin
                        cnt   <= 8'h00;
                        oe_n  <= ~rd;
                        we_n  <= rd;
                        state <= S_PULSE;
                    end
                end
                S_PULSE: begin
                    cnt <= cnt + 8'h01;
                    // Reads wait access time plus three cycles: pin register and two sync stages
                    if (cnt == (rd ? READ_CYC[7:0] : PULSE_CYC[7:0])) begin
                        if (rd)
                            rdata <= din_sync;
                        cnt   <= 8'h00;
                        oe_n  <= 1'b1;
                        we_n  <= 1'b1;
                        ce_n  <= 1'b1;
                        state <= S_HIGH;
                    end
                end
                default: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == SETUP_CYC[7:0])
                        drive <= 1'b0;
                    if (cnt == HIGH_CYC[7:0]) begin
                        done  <= 1'b1;
                        state <= S_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// ===== src/flash_host_ctrl.v
`timescale 1ns/1ps
`include "flash_host_map.vh"
module flash_host_ctrl #(
    parameter POLL_LIMIT = 32'd4000000
) (
    // Clock and reset
    input  wire        CORE_CLK,
    input  wire        SYS_RST,
    // User request
    input  wire        REQ_VALID,
    input  wire [2:0]  REQ_OP,
    input  wire [16:0] REQ_ADDR,
    input  wire [15:0] REQ_WDATA,
    output reg         REQ_READY,
    output reg         RSP_VALID,
    output reg  [15:0] RSP_RDATA,
    output reg         RSP_ERROR,
    // Flash pins
    output reg  [16:0] FL_ADDR,
    input  wire [15:0] FL_DQ_IN,
    output reg  [15:0] FL_DQ_OUT,
    output reg         FL_DQ_OE,
    output reg         FL_CE_N,
    output reg         FL_OE_N,
    output reg         FL_WE_N
);
    localparam SETUP_CYC = (`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam PULSE_CYC = (`T_WP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam READ_CYC  = (`T_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 3;
    localparam HIGH_A    = (`T_WPH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam HIGH_B    = (`T_POLL_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam HIGH_CYC  = (HIGH_A > HIGH_B) ? HIGH_A : HIGH_B;

    localparam S_IDLE  = 3'd0;
    localparam S_SEQ   = 3'd1;
    localparam S_WAIT  = 3'd2;
    localparam S_POLL1 = 3'd3;
    localparam S_POLL2 = 3'd4;
    localparam S_DONE  = 3'd5;

    reg  [15:0] dq_meta;
    reg  [15:0] dq_sync;
    reg  [2:0]  state;
    reg  [2:0]  op;
    reg  [16:0] addr;
    reg  [15:0] wdata;
    reg  [2:0]  step;
    reg  [2:0]  nsteps;
    reg         prev_tog;
    reg  [31:0] polls;
    reg         cyc_start;
    reg         cyc_read;
    reg  [16:0] next_addr;
    reg  [15:0] next_data;
    reg         cyc_last_read;
    wire        ce_n;
    wire        oe_n;
    wire        we_n;
    wire        drive;
    wire [15:0] rdata;
    wire        done;

    always @(posedge CORE_CLK) begin
        dq_meta <= FL_DQ_IN;
        dq_sync <= dq_meta;
    end

    flash_bus_cycle #(
        .SETUP_CYC (SETUP_CYC),
        .PULSE_CYC (PULSE_CYC),
        .READ_CYC  (READ_CYC),
        .HIGH_CYC  (HIGH_CYC)
    ) u_cycle (
        .clk      (CORE_CLK),
        .rst      (SYS_RST),
        .start    (cyc_start),
        .is_read  (cyc_read),
        .din_sync (dq_sync),
        .ce_n     (ce_n),
        .oe_n     (oe_n),
        .we_n     (we_n),
        .drive    (drive),
        .rdata    (rdata),
        .done     (done)
    );

    // Command word for each step of the current operation
    always @* begin
        next_addr     = {2'b00, `CMD_ADDR_A};
        next_data     = {8'h00, `CMD_UNLOCK_A};
        cyc_last_read = 1'b0;
        case (step)
            3'd0: begin
                next_addr = {2'b00, `CMD_ADDR_A};
                next_data = {8'h00, `CMD_UNLOCK_A};
            end
            3'd1: begin
                next_addr = {2'b00, `CMD_ADDR_B};
                next_data = {8'h00, `CMD_UNLOCK_B};
            end
            3'd2: begin
                next_addr = {2'b00, `CMD_ADDR_A};
                case (op)
                    `OP_PROGRAM:    next_data = {8'h00, `CMD_PROGRAM};
                    `OP_ID_READ:    next_data = {8'h00, `CMD_ID_ENTRY};
                    `OP_LOCKOUT:    next_data = {8'h00, `CMD_ERASE_SETUP};
                    default:        next_data = {8'h00, `CMD_ERASE_SETUP};
                endcase
            end
            3'd3: begin
                if (op == `OP_PROGRAM) begin
                    next_addr = addr;
                    next_data = wdata;
                end else if (op == `OP_ID_READ) begin
                    next_addr     = {16'h0000, addr[0]};
                    cyc_last_read = 1'b1;
                end else begin
                    next_data = {8'h00, `CMD_UNLOCK_A};
                end
            end
            3'd4: begin
                if (op == `OP_ID_READ) begin
                    next_data = {8'h00, `CMD_ID_EXIT};
                end else begin
                    next_addr = {2'b00, `CMD_ADDR_B};
                    next_data = {8'h00, `CMD_UNLOCK_B};
                end
            end
            default: begin
                next_addr = {2'b00, `CMD_ADDR_A};
                if (op == `OP_CHIP_ERASE) begin
                    next_data = {8'h00, `CMD_CHIP_ERASE};
                end else if (op == `OP_SECTOR_ERASE) begin
                    next_addr = addr;
                    next_data = {8'h00, `CMD_SECTOR_ERASE};
                end else begin
                    next_data = {8'h00, `CMD_LOCKOUT};
                end
            end
        endcase
    end

    always @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            state     <= S_IDLE;
            op        <= `OP_READ;
            addr      <= 17'h00000;
            wdata     <= 16'h0000;
            step      <= 3'd0;
            nsteps    <= 3'd0;
            prev_tog  <= 1'b0;
            polls     <= 32'h0;
            cyc_start <= 1'b0;
            cyc_read  <= 1'b0;
            REQ_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_RDATA <= 16'h0000;
            RSP_ERROR <= 1'b0;
            FL_ADDR   <= 17'h00000;
            FL_DQ_OUT <= 16'h0000;
            FL_DQ_OE  <= 1'b0;
            FL_CE_N   <= 1'b1;
            FL_OE_N   <= 1'b1;
            FL_WE_N   <= 1'b1;
        end else begin
            cyc_start <= 1'b0;
            RSP_VALID <= 1'b0;
            FL_CE_N   <= ce_n;
            FL_OE_N   <= oe_n;
            FL_WE_N   <= we_n;
            FL_DQ_OE  <= drive;
            case (state)
                S_IDLE: begin
                    REQ_READY <= 1'b1;
                    if (REQ_VALID && REQ_READY) begin
                        REQ_READY <= 1'b0;
                        op        <= REQ_OP;
                        addr      <= REQ_ADDR;
                        wdata     <= REQ_WDATA;
                        step      <= 3'd0;
                        RSP_ERROR <= 1'b0;
                        if (REQ_OP == `OP_READ) begin
                            FL_ADDR   <= REQ_ADDR;
                            cyc_read  <= 1'b1;
                            cyc_start <= 1'b1;
                            state     <= S_WAIT;
                        end else if (REQ_OP == `OP_PROGRAM &&
                                     REQ_ADDR <= `BOOT_LAST) begin
                            // boot block may be locked; program anyway
                            nsteps <= 3'd4;
                            state  <= S_SEQ;
                        end else begin
                            nsteps <= (REQ_OP == `OP_PROGRAM) ? 3'd4 :
                                      (REQ_OP == `OP_ID_READ) ? 3'd5 : 3'd6;
                            state  <= S_SEQ;
                        end
                    end
                end
                S_SEQ: begin
                    FL_ADDR   <= next_addr;
                    FL_DQ_OUT <= next_data;
                    cyc_read  <= cyc_last_read;
                    cyc_start <= 1'b1;
                    state     <= S_WAIT;
                end
                S_WAIT: begin
                    if (done) begin
                        step <= step + 3'd1;
                        if (cyc_read && op == `OP_ID_READ)
                            RSP_RDATA <= rdata;
                        if (op == `OP_READ) begin
                            RSP_RDATA <= rdata;
                            state     <= S_DONE;
                        end else if (step + 3'd1 < nsteps) begin
                            state <= S_SEQ;
                        end else if (op == `OP_ID_READ) begin
                            state <= S_DONE;
                        end else begin
                            FL_ADDR   <= addr;
                            cyc_read  <= 1'b1;
                            cyc_start <= 1'b1;
                            polls     <= 32'h0;
                            state     <= S_POLL1;
                        end
                    end
                end
                S_POLL1: begin
                    if (done) begin
                        // first sample is only a reference
                        prev_tog  <= rdata[6];
                        cyc_start <= 1'b1;
                        state     <= S_POLL2;
                    end
                end
                S_POLL2: begin
                    if (done) begin
                        prev_tog <= rdata[6];
                        polls    <= polls + 32'h1;
                        // OE/CE pulses advance toggle; stable means done
                        if (rdata[6] == prev_tog) begin
                            state <= S_DONE;
                        end else if (polls >= POLL_LIMIT) begin
                            RSP_ERROR <= 1'b1;
                            state     <= S_DONE;
                        end else begin
                            cyc_start <= 1'b1;
                        end
                    end
                end
                default: begin
                    RSP_VALID <= 1'b1;
                    state     <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== src/flash_host_map.vh
`ifndef FLASH_HOST_MAP_VH
`define FLASH_HOST_MAP_VH

// Command addresses and codes (low byte only)
`define CMD_ADDR_A         15'h5555
`define CMD_ADDR_B         15'h2aaa
`define CMD_UNLOCK_A       8'haa
`define CMD_UNLOCK_B       8'h55
`define CMD_ERASE_SETUP    8'h80
`define CMD_CHIP_ERASE     8'h10
`define CMD_SECTOR_ERASE   8'h30
`define CMD_PROGRAM        8'ha0
`define CMD_ID_ENTRY       8'h90
`define CMD_ID_EXIT        8'hf0
`define CMD_LOCKOUT        8'h40

// Host operation codes
`define OP_READ            3'h0
`define OP_PROGRAM         3'h1
`define OP_CHIP_ERASE      3'h2
`define OP_SECTOR_ERASE    3'h3
`define OP_ID_READ         3'h4
`define OP_LOCKOUT         3'h5

// Boot block word range
`define BOOT_FIRST         17'h00000
`define BOOT_LAST          17'h01fff

// Bus timing in ns
`define CLK_PERIOD_NS      5
`define T_SETUP_NS         10
`define T_WP_NS            100
`define T_WPH_NS           100
`define T_ACC_NS           120
`define T_POLL_HIGH_NS     150
`define T_DF_NS            30

`endif

// ===== testbench/flash_command_status_interface_tb.sv
`timescale 1ns/1ps
`include "flash_host_map.vh"
module flash_command_status_interface_tb;
    localparam MAKER = 16'h00a5;
    localparam PART  = 16'h005a;
    logic        CORE_CLK = 0;
    logic        SYS_RST = 1;
    logic        REQ_VALID = 0;
    logic [2:0]  REQ_OP = 3'h0;
    logic [16:0] REQ_ADDR = 17'h00000;
    logic [15:0] REQ_WDATA = 16'h0000;
    logic [2:0]  busy_len = 3'h2;
    logic        stuck = 0;
    wire         REQ_READY, RSP_VALID, RSP_ERROR, FL_DQ_OE, FL_CE_N, FL_OE_N, FL_WE_N;
    wire  [15:0] RSP_RDATA, FL_DQ_IN, FL_DQ_OUT;
    wire  [16:0] FL_ADDR;
    logic [15:0] got, ref_mem [int], d;
    logic [16:0] a, wrote [$];
    logic        gerr, lock_ref = 0;
    int          err_total = 0, n_checks = 0, seed;
    flash_host_ctrl #(.POLL_LIMIT(32'd50)) uut (.CORE_CLK, .SYS_RST, .REQ_VALID, .REQ_OP,
        .REQ_ADDR, .REQ_WDATA, .REQ_READY, .RSP_VALID, .RSP_RDATA, .RSP_ERROR, .FL_ADDR,
        .FL_DQ_IN, .FL_DQ_OUT, .FL_DQ_OE, .FL_CE_N, .FL_OE_N, .FL_WE_N);
    flash_dev_model #(.MAKER_ID(MAKER), .PART_ID(PART)) dev (.addr(FL_ADDR),
        .dq_host(FL_DQ_OUT), .dq_host_en(FL_DQ_OE), .ce_n(FL_CE_N), .oe_n(FL_OE_N),
        .we_n(FL_WE_N), .dq(FL_DQ_IN), .busy_len(busy_len), .stuck(stuck));
    initial forever #2.5 CORE_CLK = ~CORE_CLK;
    function automatic int sect(int x);
        return x < 32'h6000 ? x >> 13 : 3;
    endfunction
    task automatic miss(input string msg);
        err_total++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk_data(input [15:0] exp);
        n_checks++;
        if (got !== exp) miss($sformatf("data %h want %h", got, exp));
    endtask
    task automatic chk_err(input exp);
        n_checks++;
        if (gerr !== exp) miss("error flag");
    endtask
    task automatic run(input [2:0] op, input [16:0] ad, input [15:0] wd);
        int n;
        for (n = 0; REQ_READY !== 1'b1 && n < 200; n++) @(negedge CORE_CLK);
        if (n == 200) begin
            miss("never ready");
            test_done;
        end
        REQ_OP = op;
        REQ_ADDR = ad;
        REQ_WDATA = wd;
        REQ_VALID = 1;
        @(negedge CORE_CLK);
        REQ_VALID = 0;
        for (n = 0; RSP_VALID !== 1'b1 && n < 20000; n++) @(negedge CORE_CLK);
        if (n == 20000) begin
            miss("no answer");
            test_done;
        end else begin
            got = RSP_RDATA;
            gerr = RSP_ERROR;
        end
    endtask
    task automatic rd_chk(input [16:0] ad);
        run(`OP_READ, ad, 16'h0000);
        chk_data(ref_mem.exists(ad) ? ref_mem[ad] : 16'hffff);
    endtask
    task automatic prog(input [16:0] ad, input [15:0] wd);
        busy_len = 3'($random(seed));
        run(`OP_PROGRAM, ad, wd);
        chk_err(1'b0);
        if (!(lock_ref && ad <= `BOOT_LAST)) ref_mem[ad] = wd;
    endtask
    task automatic erase(input bit chip, input [16:0] ad);
        run(chip ? `OP_CHIP_ERASE : `OP_SECTOR_ERASE, ad, 16'h0000);
        chk_err(1'b0);
        foreach (ref_mem[k])
            if ((chip || sect(k) == sect(ad)) && !(lock_ref && k <= `BOOT_LAST))
                ref_mem[k] = 16'hffff;
    endtask
    initial begin
        seed = 32'hc464;
        repeat (12) @(negedge CORE_CLK);
        SYS_RST = 0;
        run(`OP_ID_READ, 17'h00000, 16'h0000);
        chk_data(MAKER);
        run(`OP_ID_READ, 17'h00001, 16'hff00);
        chk_data(PART);
        rd_chk(17'h02000);
        $display("identification test done");
        repeat (4) begin
            a = 17'(32'h2000 + {$random(seed)} % 32'h1e000);
            d = 16'($random(seed));
            prog(a, d);
            wrote.push_back(a);
        end
        foreach (wrote[k]) rd_chk(wrote[k]);
        erase(0, wrote[0]);
        foreach (wrote[k]) rd_chk(wrote[k]);
        $display("program and sector erase test done");
        prog(17'h01fff, d);
        run(`OP_LOCKOUT, 17'h00000, 16'h0000);
        chk_err(1'b0);
        lock_ref = 1;
        prog(17'h01fff, ~d);
        prog(17'h02000, d);
        rd_chk(17'h01fff);
        rd_chk(17'h02000);
        erase(1, 17'h00000);
        rd_chk(17'h02000);
        rd_chk(wrote[1]);
        $display("lockout and chip erase test done");
        // Second reset between operations; the flash keeps its own state
        SYS_RST = 1;
        repeat (3) @(negedge CORE_CLK);
        SYS_RST = 0;
        // A busy time of zero would let the stuck program finish cleanly
        busy_len = 3'h3;
        stuck = 1;
        run(`OP_PROGRAM, 17'h03000, 16'h1234);
        chk_err(1'b1);
        stuck = 0;
        rd_chk(17'h02000);
        chk_err(1'b0);
        $display("poll timeout test done");
        test_done;
    end
endmodule

// ===== testbench/flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model #(
    parameter MAKER_ID = 16'h00a5,
    parameter PART_ID  = 16'h005a
) (
    // Host pins
    input  wire [16:0] addr,
    input  wire [15:0] dq_host,
    input  wire        dq_host_en,
    input  wire        ce_n,
    input  wire        oe_n,
    input  wire        we_n,
    output wire [15:0] dq,
    // Test controls
    input  wire [2:0]  busy_len,
    input  wire        stuck
);
    logic [15:0] mem [int];
    logic [15:0] rd  = 16'h0000;
    logic [1:0]  st  = 2'h0;
    logic        er  = 0;
    logic        prg = 0;
    logic        lock = 0;
    logic        tog = 0;
    logic        rok = 0;
    int          busy = 0;
    wire  [14:0] ca  = addr[14:0];
    wire  [7:0]  cd  = dq_host[7:0];
    // A write ends on whichever strobe rises first, both together included
    wire         wr_n = we_n | ce_n;
    logic        idm = 0;
    function automatic int sect(int a);
        return a < 32'h6000 ? a >> 13 : 3;
    endfunction
    // Released data shows the inverse of the last word
    assign dq = dq_host_en ? dq_host : (!ce_n && !oe_n && rok) ? rd : ~rd;
    // low byte and low address decode
    always @(posedge wr_n) if (busy == 0) begin
        if (prg) begin
            if (!(lock && addr <= 17'h01fff)) mem[addr] = dq_host;
            prg  = 0;
            busy = busy_len;
        end else if (cd == 8'hf0) begin
            idm = 0;
            st  = 2'h0;
        end else if (st == 2'h0 && cd == 8'haa && ca == 15'h5555) st = 2'h1;
        else if (st == 2'h1 && cd == 8'h55 && ca == 15'h2aaa) st = 2'h2;
        else if (st == 2'h2) begin
            st = 2'h0;
            if (er) begin
                er   = 0;
                busy = busy_len;
                foreach (mem[k])
                    if (!(lock && k < 32'h2000) && ((cd == 8'h10 && ca == 15'h5555)
                        || (cd == 8'h30 && sect(k) == sect(addr)))) mem[k] = 16'hffff;
                if (cd == 8'h40 && ca == 15'h5555) lock = 1;
            end else begin
                prg = cd == 8'ha0;
                er  = cd == 8'h80;
                idm = idm || cd == 8'h90;
            end
        end else st = 2'h0;
    end
    always @(negedge oe_n or negedge ce_n) if (!oe_n && !ce_n) begin
        rok = 0;
        if (busy > 0) begin
            tog = ~tog;
            rd  = {9'h000, tog, 6'h00};
            if (!stuck) busy = busy - 1;
        end else if (idm) rd = addr[0] ? PART_ID : MAKER_ID;
        else rd = mem.exists(addr) ? mem[addr] : 16'hffff;
        #50 rok = 1;
    end
    always @(negedge stuck) busy = 0;
endmodule

// ===== testbench/flash_host_ctrl_chk.sv
`timescale 1ns/1ps
module flash_host_chk (
    // Clock and reset
    input wire        CORE_CLK,
    input wire        SYS_RST,
    // User side
    input wire        REQ_VALID,
    input wire        REQ_READY,
    input wire        RSP_VALID,
    // Flash pins
    input wire [16:0] FL_ADDR,
    input wire        FL_DQ_OE,
    input wire        FL_CE_N,
    input wire        FL_OE_N,
    input wire        FL_WE_N
);
    logic [7:0] we_low;
    logic [7:0] oe_high;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    // Idle time before the first read counts as long enough
    always @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            we_low  <= 8'h00;
            oe_high <= 8'hff;
        end else begin
            we_low  <= FL_WE_N ? 8'h00 : we_low + 8'h01;
            oe_high <= !FL_OE_N ? 8'h00 : oe_high + {7'h00, oe_high != 8'hff};
        end
    end
    sequence s_take;
        REQ_VALID && REQ_READY;
    endsequence
    sequence s_read_held;
        !FL_OE_N ##1 !FL_OE_N;
    endsequence
    a_strobe_excl: assert property (!FL_WE_N |-> FL_OE_N && !FL_CE_N)
        else $error("write strobe without select or with output enable");
    a_cmd_driven: assert property (!FL_WE_N |-> FL_DQ_OE)
        else $error("write strobe while data not driven");
    a_we_width: assert property ($rose(FL_WE_N) |-> we_low >= 8'h14)
        else $error("write pulse too short");
    a_poll_high: assert property ($fell(FL_OE_N) |-> oe_high >= 8'h1e)
        else $error("output enable high time too short");
    a_addr_held: assert property (s_read_held |-> $stable(FL_ADDR))
        else $error("address moved during read");
    a_no_contend: assert property (!FL_OE_N |-> !FL_DQ_OE)
        else $error("host drives data during read");
    a_rsp_pulse: assert property (RSP_VALID |=> !RSP_VALID)
        else $error("response longer than one cycle");
    a_take_busy: assert property (s_take |=> !REQ_READY [*4])
        else $error("ready did not drop after take");
    a_reset_idle: assert property ($fell(SYS_RST) |-> FL_CE_N && FL_OE_N && FL_WE_N
        && !FL_DQ_OE && !REQ_READY)
        else $error("pins not idle after reset");
endmodule
bind flash_host_ctrl flash_host_chk u_chk (.CORE_CLK, .SYS_RST, .REQ_VALID, .REQ_READY,
    .RSP_VALID, .FL_ADDR, .FL_DQ_OE, .FL_CE_N, .FL_OE_N, .FL_WE_N);
